// [sim/tb_top.sv]
`timescale 1ns/100ps
module tb_top
   import tcr_pkg::*;
;
   // ---------------------------------------------------------------
   // Signals
   // ---------------------------------------------------------------
   logic       clock;
   logic       rst_n;
   logic       reg_wr;
   logic       reg_rd;
   logic [7:0] reg_addr;
   logic [7:0] reg_wdata;
   logic [7:0] reg_rdata;
   logic       reg_rvalid;
   logic       factory_defaults_loaded;
   logic       wake_event;
   logic       deep_sleep_active;
   logic       soft_reset_active;
   logic [2:0] function_select;
   logic [3:0] host_output;
   logic [7:0] rdat;
   logic       rok;
   logic [2:0] fexp;
   int         err_count;
   int         num_checks;
   int         cycles;
   int         n;

   tcr_operating_regs i_dut (
      .clock(clock), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
      .factory_defaults_loaded(factory_defaults_loaded), .wake_event(wake_event),
      .deep_sleep_active(deep_sleep_active), .soft_reset_active(soft_reset_active),
      .function_select(function_select), .host_output(host_output));

   tcr_host_model i_host (
      .clock(clock), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

   // ---------------------------------------------------------------
   // Checking helpers
   // ---------------------------------------------------------------
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      num_checks++;
      if (got !== exp) begin
         $display("unexpected %s expected %h seen %h", what, exp, got);
         err_count++;
      end
   endtask

   // Read one register and compare
   task automatic rchk(input logic [7:0] addr, input logic [7:0] exp);
      i_host.rd(addr, rdat, rok);
      chk("read valid", 8'h01, {7'h00, rok});
      chk("read data", exp, rdat);
   endtask

   // Bounded wait for deep sleep (0) or soft reset (1) to reach a level
   task automatic wait_sig(input logic sel, input logic lvl);
      int k;
      k = 0;
      while (((sel ? soft_reset_active : deep_sleep_active) !== lvl) && k < 20) begin
         @(posedge clock);
         #1;
         k++;
      end
   endtask

   task automatic report_and_stop;
      if (err_count == 0 && num_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // ---------------------------------------------------------------
   // Clock and hang guard
   // ---------------------------------------------------------------
   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end

   always @(posedge clock) begin
      cycles++;
      if (cycles > 4000) begin
         err_count++;
         report_and_stop();
      end
   end

   // ---------------------------------------------------------------
   // Test sequence, once per strap level
   // ---------------------------------------------------------------
   initial begin
      rst_n                   = 1'b0;
      factory_defaults_loaded = 1'b0;
      wake_event              = 1'b0;
      for (int p = 0; p < 2; p++) begin
         factory_defaults_loaded = p[0];
         rst_n = 1'b0;
         repeat (10) @(posedge clock);
         #1 rst_n = 1'b1;
         repeat (2) @(posedge clock);
         #1;
         // Power-on values and status
         rchk(TCR_OFS_OPERATING_CONTROL, 8'h00);
         rchk(TCR_OFS_HOST_OUTPUT_LEVELS, 8'h00);
         rchk(TCR_OFS_CONFIG_SOURCE_STATUS, {1'b0, p[0], 6'h00});
         chk("deep sleep idle", 8'h00, {7'h00, deep_sleep_active});
         i_host.wr(TCR_OFS_CONFIG_SOURCE_STATUS, 8'hFF);
         rchk(TCR_OFS_CONFIG_SOURCE_STATUS, {1'b0, p[0], 6'h00});
         i_host.wr(TCR_OFS_RESERVED_02, 8'hFF);
         rchk(TCR_OFS_RESERVED_02, TCR_UNDEFINED_READ);
         rchk(8'h20, 8'h00);
         // Host outputs follow the upper nibble
         for (int i = 0; i < 4; i++) begin
            i_host.wr(TCR_OFS_HOST_OUTPUT_LEVELS, 8'h1F << i);
            chk("host output", 8'h0F >> (3 - i), {4'h0, host_output});
            rchk(TCR_OFS_HOST_OUTPUT_LEVELS, (8'h0F >> (3 - i)) << 4);
         end
         // Function codes, invalid ones dropped
         for (int c = 0; c < 8; c++) begin
            fexp = (c < 5) ? c[2:0] : TCR_FN_DEBUG_DATA;
            i_host.wr(TCR_OFS_OPERATING_CONTROL, {5'h00, c[2:0]});
            chk("function", {5'h00, fexp}, {5'h00, function_select});
            rchk(TCR_OFS_OPERATING_CONTROL, {5'h00, fexp});
         end
         repeat (3) @(posedge clock);
         #1 chk("soft reset idle", 8'h00, {7'h00, soft_reset_active});
         // Deep sleep entry, hold and wake
         i_host.wr(TCR_OFS_OPERATING_CONTROL, 8'h12);
         wait_sig(1'b0, 1'b1);
         chk("deep sleep on", 8'h01, {7'h00, deep_sleep_active});
         rchk(TCR_OFS_OPERATING_CONTROL, 8'h12);
         repeat (20) @(posedge clock);
         #1 chk("deep sleep held", 8'h01, {7'h00, deep_sleep_active});
         wake_event = 1'b1;
         @(posedge clock);
         #1 wake_event = 1'b0;
         wait_sig(1'b0, 1'b0);
         chk("deep sleep off", 8'h00, {7'h00, deep_sleep_active});
         rchk(TCR_OFS_OPERATING_CONTROL, 8'h02);
         // Soft reset length and restored state
         i_host.wr(TCR_OFS_OPERATING_CONTROL, 8'h0B);
         wait_sig(1'b1, 1'b1);
         n = 0;
         while (soft_reset_active === 1'b1 && n < 100) begin
            @(posedge clock);
            #1;
            n++;
         end
         chk("soft reset length", TCR_SOFT_RESET_CYCLES[7:0], n[7:0]);
         chk("function after reset", 8'h00, {5'h00, function_select});
         chk("outputs after reset", 8'h00, {4'h0, host_output});
         rchk(TCR_OFS_OPERATING_CONTROL, 8'h00);
      end
      report_and_stop();
   end
endmodule

// [sim/tcr_host_model.sv]
`timescale 1ns/100ps
module tcr_host_model
   import tcr_pkg::*;
(
   // Clock
   input  wire logic       clock,
   // Register port
   output      logic       reg_wr,
   output      logic       reg_rd,
   output      logic [7:0] reg_addr,
   output      logic [7:0] reg_wdata,
   input  wire logic [7:0] reg_rdata,
   input  wire logic       reg_rvalid
);
   // ---------------------------------------------------------------
   // Port idle state
   // ---------------------------------------------------------------
   initial begin
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
      reg_addr  = 8'hA5;
      reg_wdata = 8'h5A;
   end

   // ---------------------------------------------------------------
   // Byte transfers
   // ---------------------------------------------------------------
   // Write strobe held for one taking edge
   task automatic wr(input logic [7:0] addr, input logic [7:0] data);
      @(posedge clock);
      #1;
      reg_wr    = 1'b1;
      reg_addr  = addr;
      reg_wdata = data;
      @(posedge clock);
      #1;
      reg_wr    = 1'b0;
      reg_addr  = ~addr; // Released lines show no stale value
      reg_wdata = ~data;
   endtask

   // Read strobe, answer taken one cycle later
   task automatic rd(input logic [7:0] addr, output logic [7:0] data, output logic ok);
      @(posedge clock);
      #1;
      reg_rd   = 1'b1;
      reg_addr = addr;
      @(posedge clock);
      #1;
      reg_rd   = 1'b0;
      reg_addr = ~addr;
      ok       = reg_rvalid;
      data     = reg_rdata;
   endtask
endmodule

// [verilog/tcr_op_if.sv]
`timescale 1ns/100ps
interface tcr_op_if;
   // Requests from the register bank
   logic sleep_bit;
   logic reset_bit;
   logic wake_event;
   // State and completion from the sequencer
   logic deep_active;
   logic reset_active;
   logic sleep_done;
   logic reset_done;

   modport bank (output sleep_bit, output reset_bit, output wake_event,
                 input deep_active, input reset_active, input sleep_done, input reset_done);
   modport seq  (input sleep_bit, input reset_bit, input wake_event,
                 output deep_active, output reset_active, output sleep_done, output reset_done);
endinterface

// [verilog/tcr_operating_regs.sv]
// Behaviour
// R1 - Every register has a fixed access kind and a fixed value right after reset.
// R2 - The reserved offset holds nothing and reads back a meaningless value, here zero.
// R3 - Reserved bits do nothing; writes to them are dropped and they read as zero.
// R4 - Read/write registers with reset value zero read zero after reset and take host writes.
// R5 - Writing one to bit 4 at offset 00h puts the device into deep sleep; the bit clears on exit.
// R6 - While bit 4 reads zero the device stays in normal sleep, not deep sleep.
// R7 - Writing one to bit 3 at offset 00h resets the controller; writing zero does nothing.
// R8 - The deep sleep and soft reset bits clear themselves once their operation is done.
// R9 - Bits 2:0 at offset 00h pick the function; codes 101 to 111 are invalid and ignored.
// R10 - Bits 7:4 at offset 01h drive host outputs 3:0, zero low and one high.
// R11 - Bit 6 at offset 03h reads one when factory defaults were loaded, zero for user setup.
// R12 - Writes to the status register at offset 03h change nothing.
`timescale 1ns/100ps
module tcr_operating_regs
   import tcr_pkg::*;
(
   // Clock and reset
   input  wire logic       clock,
   input  wire logic       rst_n,
   // Register port
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   output      logic [7:0] reg_rdata,
   output      logic       reg_rvalid,
   // Device core
   input  wire logic       factory_defaults_loaded,
   input  wire logic       wake_event,
   output      logic       deep_sleep_active,
   output      logic       soft_reset_active,
   output      logic [2:0] function_select,
   // Host controlled outputs
   output      logic [3:0] host_output
);

   // ---------------------------------------------------------------
   // Storage
   // ---------------------------------------------------------------
   tcr_op_if   op ();
   logic       sleep_bit;
   logic       reset_bit;
   logic       strap_taken;
   logic       factory_flag;
   logic       wr_ctrl;
   logic       wr_out;
   logic       mode_ok;
   logic [7:0] next_rdata;

   // Access decode; the status offset has no write path
   assign wr_ctrl = reg_wr && (reg_addr == TCR_OFS_OPERATING_CONTROL);
   assign wr_out  = reg_wr && (reg_addr == TCR_OFS_HOST_OUTPUT_LEVELS); // R12
   assign mode_ok = (reg_wdata[TCR_MODE_MSB:0] <= TCR_FN_DEBUG_DATA); // R9

   // ---------------------------------------------------------------
   // Sequencer
   // ---------------------------------------------------------------

   // Bank side of the link
   assign op.sleep_bit  = sleep_bit;
   assign op.reset_bit  = reset_bit;
   assign op.wake_event = wake_event;

   tcr_power_seq u_seq (
      .clock (clock),
      .rst_n (rst_n),
      .op    (op.seq)
   );

   // ---------------------------------------------------------------
   // Operating control
   // ---------------------------------------------------------------

   // Deep sleep bit: host set wins over the done clear
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         sleep_bit <= TCR_RST_OPERATING_CONTROL[TCR_BIT_DEEP_SLEEP]; // R1
      end else if (wr_ctrl && reg_wdata[TCR_BIT_DEEP_SLEEP]) begin
         sleep_bit <= 1'b1; // R5
      end else if (op.sleep_done || op.reset_done) begin
         sleep_bit <= 1'b0; // R8
      end
   end

   // Soft reset bit: writing zero leaves it alone
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         reset_bit <= TCR_RST_OPERATING_CONTROL[TCR_BIT_SOFT_RESET];
      end else if (wr_ctrl && reg_wdata[TCR_BIT_SOFT_RESET]) begin
         reset_bit <= 1'b1; // R7
      end else if (op.reset_done) begin
         reset_bit <= 1'b0; // R8
      end
   end

   // Function selector; invalid codes are dropped, soft reset returns to normal
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         function_select <= TCR_RST_OPERATING_CONTROL[TCR_MODE_MSB:0]; // R4
      end else if (wr_ctrl && mode_ok) begin
         function_select <= reg_wdata[TCR_MODE_MSB:0]; // R9
      end else if (op.reset_done) begin
         function_select <= TCR_FN_NORMAL; // R7
      end
   end

   // ---------------------------------------------------------------
   // Host outputs
   // ---------------------------------------------------------------

   // Upper nibble drives the pins, soft reset returns them low
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         host_output <= TCR_RST_HOST_OUTPUT_LEVELS[TCR_OUT_MSB:TCR_OUT_LSB]; // R4
      end else if (wr_out) begin
         host_output <= reg_wdata[TCR_OUT_MSB:TCR_OUT_LSB]; // R10
      end else if (op.reset_done) begin
         host_output <= TCR_RST_HOST_OUTPUT_LEVELS[TCR_OUT_MSB:TCR_OUT_LSB];
      end
   end

   // ---------------------------------------------------------------
   // Configuration source status
   // ---------------------------------------------------------------

   // Strap caught once, on the first edge after reset release
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         strap_taken  <= 1'b0;
         factory_flag <= TCR_RST_STATUS[TCR_BIT_FACTORY_LOADED];
      end else if (!strap_taken) begin
         strap_taken  <= 1'b1;
         factory_flag <= factory_defaults_loaded; // R11
      end
   end

   // ---------------------------------------------------------------
   // Core state outputs
   // ---------------------------------------------------------------

   // Registered copies of sequencer state
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         deep_sleep_active <= 1'b0;
         soft_reset_active <= 1'b0;
      end else begin
         deep_sleep_active <= op.deep_active; // R6
         soft_reset_active <= op.reset_active;
      end
   end

   // ---------------------------------------------------------------
   // Read path
   // ---------------------------------------------------------------

   // Read mux; reserved bits and offsets give zero
   always_comb begin
      next_rdata = TCR_UNDEFINED_READ; // R2
      case (reg_addr)
         TCR_OFS_OPERATING_CONTROL: begin
            next_rdata[TCR_BIT_DEEP_SLEEP]  = sleep_bit;
            next_rdata[TCR_BIT_SOFT_RESET]  = reset_bit;
            next_rdata[TCR_MODE_MSB:0]      = function_select; // R3
         end
         TCR_OFS_HOST_OUTPUT_LEVELS: begin
            next_rdata[TCR_OUT_MSB:TCR_OUT_LSB] = host_output;
         end
         TCR_OFS_CONFIG_SOURCE_STATUS: begin
            next_rdata[TCR_BIT_FACTORY_LOADED] = factory_flag; // R11
         end
         default: begin
            next_rdata = TCR_UNDEFINED_READ; // R2
         end
      endcase
   end

   // Read data one cycle after the request
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata  <= 8'h00;
         reg_rvalid <= 1'b0;
      end else begin
         reg_rvalid <= reg_rd;
         if (reg_rd) begin
            reg_rdata <= next_rdata;
         end
      end
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   sequence s_reset_write;
      wr_ctrl && reg_wdata[TCR_BIT_SOFT_RESET] && !op.deep_active && !op.reset_active;
   endsequence

   sequence s_reset_entry;
      reset_bit ##1 op.reset_active ##1 soft_reset_active;
   endsequence

   AST_SOFT_RESET_START: assert property (s_reset_write |=> s_reset_entry) // R7
      else $error("soft reset did not start after request");

   AST_ZERO_NO_RESET: assert property (wr_ctrl && !reg_wdata[TCR_BIT_SOFT_RESET] && !reset_bit // R7
      |=> !reset_bit)
      else $error("writing zero started a soft reset");

   AST_SLEEP_SELF_CLEAR: assert property (op.sleep_done && !(wr_ctrl && reg_wdata[TCR_BIT_DEEP_SLEEP]) // R8
      |=> !sleep_bit ##1 !deep_sleep_active)
      else $error("deep sleep bit did not clear after wake");

   AST_DEEP_ONLY_WITH_BIT: assert property (!sleep_bit && !op.deep_active |=> !op.deep_active) // R6
      else $error("deep sleep without bit set");

   sequence s_sleep_write;
      wr_ctrl && reg_wdata[TCR_BIT_DEEP_SLEEP] && !reg_wdata[TCR_BIT_SOFT_RESET]
         && !sleep_bit && !reset_bit && !op.reset_active && !op.deep_active;
   endsequence

   sequence s_sleep_entry;
      sleep_bit ##1 op.deep_active ##1 deep_sleep_active;
   endsequence

   AST_SLEEP_ENTRY: assert property (s_sleep_write |=> s_sleep_entry) // R5
      else $error("deep sleep not entered after request");

   AST_MODE_INVALID: assert property (wr_ctrl && !mode_ok && !op.reset_done // R9
      |=> $stable(function_select))
      else $error("invalid function code was taken");

   AST_OUTPUT_LEVEL: assert property (wr_out |=> host_output == $past(reg_wdata[TCR_OUT_MSB:TCR_OUT_LSB])) // R10
      else $error("host outputs do not follow the write");

   AST_STATUS_READ: assert property (reg_rd && reg_addr == TCR_OFS_CONFIG_SOURCE_STATUS // R11
      |=> reg_rvalid && reg_rdata == {1'b0, $past(factory_flag), 6'h00})
      else $error("status read wrong");

   AST_STATUS_NO_WRITE: assert property (reg_wr && reg_addr == TCR_OFS_CONFIG_SOURCE_STATUS // R12
      && strap_taken && !op.reset_done |=> $stable(factory_flag) && $stable(host_output))
      else $error("status write changed state");

   AST_OUT_RESERVED_ZERO: assert property (reg_rd && reg_addr == TCR_OFS_HOST_OUTPUT_LEVELS // R3
      |=> reg_rdata[3:0] == 4'h0)
      else $error("reserved bits of output register read nonzero");

   AST_RESERVED_OFS: assert property (reg_rd && reg_addr == TCR_OFS_RESERVED_02 |=> reg_rdata == 8'h00) // R2
      else $error("reserved offset read nonzero");

   // ---------------------------------------------------------------
   // Port, mirror and self-clear checks
   // ---------------------------------------------------------------
   AST_RESERVED_NO_WRITE: assert property (reg_wr && reg_addr == TCR_OFS_RESERVED_02 && !op.reset_done // R2
      |=> $stable(function_select) && $stable(host_output))
      else $error("write to reserved offset changed state");

   AST_CTRL_RESERVED_ZERO: assert property (reg_rd && reg_addr == TCR_OFS_OPERATING_CONTROL // R3
      |=> reg_rdata[7:5] == 3'h0)
      else $error("reserved bits of control register read nonzero");

   AST_RVALID_ONE_SHOT: assert property (!reg_rd |=> !reg_rvalid) // R1
      else $error("read answer without a read");

   AST_RVALID_ON_READ: assert property (reg_rd |=> reg_rvalid) // R1
      else $error("read got no answer");

   AST_RDATA_HOLD: assert property (!reg_rd |=> $stable(reg_rdata)) // R1
      else $error("read data changed without a read");

   AST_FN_VALID: assert property (function_select <= TCR_FN_DEBUG_DATA) // R9
      else $error("function selector holds an invalid code");

   AST_RESET_CLEARS: assert property (op.reset_done && !wr_ctrl // R8
      |=> !reset_bit && !sleep_bit && function_select == TCR_FN_NORMAL)
      else $error("soft reset did not clear the control register");

   AST_OUT_RESET: assert property (op.reset_done && !wr_out // R7
      |=> host_output == TCR_RST_HOST_OUTPUT_LEVELS[TCR_OUT_MSB:TCR_OUT_LSB])
      else $error("soft reset did not return host outputs to reset level");

   AST_OUT_HOLD: assert property (!wr_out && !op.reset_done |=> $stable(host_output)) // R10
      else $error("host outputs changed without a write");

   AST_STATUS_STICKY: assert property (strap_taken |=> $stable(factory_flag)) // R11
      else $error("status flag changed after power-up");

   AST_DEEP_MIRROR: assert property (op.deep_active |=> deep_sleep_active) // R6
      else $error("deep sleep output missed the sequencer state");

   AST_DEEP_MIRROR_LOW: assert property (!op.deep_active |=> !deep_sleep_active) // R6
      else $error("deep sleep output high outside deep sleep");

   AST_RESET_MIRROR: assert property (op.reset_active |=> soft_reset_active) // R7
      else $error("soft reset output missed the sequencer state");

   AST_RESET_MIRROR_LOW: assert property (!op.reset_active |=> !soft_reset_active) // R7
      else $error("soft reset output high outside soft reset");

   AST_SLEEP_SET_WINS: assert property (wr_ctrl && reg_wdata[TCR_BIT_DEEP_SLEEP] |=> sleep_bit) // R5
      else $error("deep sleep request was lost");

   AST_RESET_SET_WINS: assert property (wr_ctrl && reg_wdata[TCR_BIT_SOFT_RESET] |=> reset_bit) // R7
      else $error("soft reset request was lost");

endmodule

// [verilog/tcr_pkg.sv]
package tcr_pkg;

   // ---------------------------------------------------------------
   // Register offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] TCR_OFS_OPERATING_CONTROL    = 8'h00;
   localparam logic [7:0] TCR_OFS_RESERVED_02          = 8'h02;
   localparam logic [7:0] TCR_OFS_HOST_OUTPUT_LEVELS   = 8'h01;
   localparam logic [7:0] TCR_OFS_CONFIG_SOURCE_STATUS = 8'h03;

   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int TCR_BIT_DEEP_SLEEP    = 4;
   localparam int TCR_BIT_SOFT_RESET    = 3;
   localparam int TCR_MODE_MSB          = 2;
   localparam int TCR_OUT_MSB           = 7;
   localparam int TCR_OUT_LSB           = 4;
   localparam int TCR_BIT_FACTORY_LOADED = 6;

   // ---------------------------------------------------------------
   // Values after reset
   // ---------------------------------------------------------------
   localparam logic [7:0] TCR_RST_OPERATING_CONTROL  = 8'h00;
   localparam logic [7:0] TCR_RST_HOST_OUTPUT_LEVELS = 8'h00;
   localparam logic [7:0] TCR_RST_STATUS             = 8'h00;
   localparam logic [7:0] TCR_UNDEFINED_READ         = 8'h00;

   // ---------------------------------------------------------------
   // Function selector codes
   // ---------------------------------------------------------------
   localparam logic [2:0] TCR_FN_NORMAL     = 3'h0;
   localparam logic [2:0] TCR_FN_LED_SETUP  = 3'h1;
   localparam logic [2:0] TCR_FN_DEV_SETUP  = 3'h2;
   localparam logic [2:0] TCR_FN_PROD_TEST  = 3'h3;
   localparam logic [2:0] TCR_FN_DEBUG_DATA = 3'h4;

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int TCR_CLOCK_PERIOD_NS     = 40;
   localparam int TCR_SOFT_RESET_NS       = 1000;
   localparam int TCR_SOFT_RESET_CYCLES   =
      (TCR_SOFT_RESET_NS + TCR_CLOCK_PERIOD_NS - 1) / TCR_CLOCK_PERIOD_NS;
   localparam logic [4:0] TCR_SOFT_RESET_LAST = 5'(TCR_SOFT_RESET_CYCLES - 1);

   // Sequencer states
   typedef enum logic [1:0] {
      TCR_SEQ_IDLE,
      TCR_SEQ_DEEP,
      TCR_SEQ_RESET
   } tcr_seq_state_t;

endpackage

// [verilog/tcr_power_seq.sv]
`timescale 1ns/100ps
module tcr_power_seq
   import tcr_pkg::*;
(
   // Clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // Link to the register bank
   tcr_op_if.seq    op
);

   tcr_seq_state_t state;
   logic [4:0]     reset_count;

   // ---------------------------------------------------------------
   // Sequencer state
   // ---------------------------------------------------------------

   // Soft reset wins over deep sleep and its end clears the sleep bit; stay idle while neither set
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state <= TCR_SEQ_IDLE;
      end else begin
         case (state)
            TCR_SEQ_IDLE: begin
               if (op.reset_bit) begin
                  state <= TCR_SEQ_RESET; // R7
               end else if (op.sleep_bit) begin
                  state <= TCR_SEQ_DEEP; // R5
               end
            end
            TCR_SEQ_DEEP: begin
               if (op.wake_event) begin
                  state <= TCR_SEQ_IDLE;
               end
            end
            TCR_SEQ_RESET: begin
               if (reset_count == TCR_SOFT_RESET_LAST) begin
                  state <= TCR_SEQ_IDLE;
               end
            end
            default: begin
               state <= TCR_SEQ_IDLE;
            end
         endcase
      end
   end

   // Length of the soft reset pulse
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         reset_count <= 5'h00;
      end else if (state == TCR_SEQ_RESET) begin
         reset_count <= reset_count + 5'h01;
      end else begin
         reset_count <= 5'h00;
      end
   end

   // ---------------------------------------------------------------
   // Status toward the bank
   // ---------------------------------------------------------------

   // Done strobes clear the self-clearing bits in the bank
   assign op.deep_active  = (state == TCR_SEQ_DEEP);
   assign op.reset_active = (state == TCR_SEQ_RESET);
   assign op.sleep_done   = (state == TCR_SEQ_DEEP) && op.wake_event; // R8
   assign op.reset_done   = (state == TCR_SEQ_RESET) && (reset_count == TCR_SOFT_RESET_LAST); // R8

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   AST_RESET_LENGTH: assert property (@(posedge clock) disable iff (!rst_n) // R7
      $rose(op.reset_active) |-> op.reset_active[*8] ##[17:17] op.reset_done)
      else $error("soft reset pulse has wrong length");

   AST_DEEP_NEEDS_BIT: assert property (@(posedge clock) disable iff (!rst_n) // R6
      $rose(op.deep_active) |-> $past(op.sleep_bit) && !$past(op.reset_bit))
      else $error("deep sleep entered without its request bit");

endmodule
